// *** core/cmf_pkg.sv ***
// Package: register map, field layout and reset values for the message center format block
//
// Overview of operation
// - Transmitter sends as many data bytes as the byte count field holds, at most 8; larger counts send 8.
// - On reception the byte count field is loaded with the received byte count.
// - Direction bit 3: one makes a transmitter, zero makes a receiver.
// - Format bit selects 29-bit or 11-bit identifiers; other format is never accepted.
// - Identifier mask enable bit 1 switches identifier masking on or off.
// - Masking off: every identifier bit must equal the arbitration bits.
// - Masking off: a remote request is answered only on an exact match.
// - Masking on: only positions with mask bit one are compared.
// - On a masked match the whole message, arbitration bits included, is loaded; the code loads only the identifier and byte count, no data bytes.
// - Direction and both mask enables change only while the ready flag is zero.
// - Data mask enable includes first two data bytes, masked against arbitration 0 and 1.
`default_nettype none
package cmf_pkg;
  // Byte addresses of the APB registers
  localparam logic [7:0] ADDR_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_ARB = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_RXID = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // Format register fields
  localparam int BC_HI = 7;
  localparam int BC_LO = 4;
  localparam int DIR_BIT = 3;
  localparam int FMT_BIT = 2;
  localparam int IDM_BIT = 1;
  localparam int DBM_BIT = 0;
  // Control register fields
  localparam int RDY_BIT = 0;
  // Reset values
  localparam logic [7:0] FORMAT_RST = 8'h00;
  localparam logic [28:0] ARB_RST = 29'h0;
  localparam logic [28:0] MASK_RST = 29'h0;
  localparam logic [15:0] DMASK_RST = 16'h0;
  localparam logic [3:0] BC_MAX = 4'h8;
  localparam logic [31:0] RD_ZERO = 32'h0;
endpackage
`default_nettype wire

// *** core/cmf_id_cmp.sv ***
// Masked comparator between received bits and stored arbitration bits
`default_nettype none
module cmf_id_cmp #(
  parameter int W = 29
) (
  input wire logic [W-1:0] rx,
  input wire logic [W-1:0] arb,
  input wire logic [W-1:0] mask,
  input wire logic use_mask,
  output logic hit
);
  logic [W-1:0] eff;
  assign eff = use_mask ? mask : {W{1'b1}};
  assign hit = ((rx ^ arb) & eff) == '0;
endmodule
`default_nettype wire

// *** core/cmf_tx_count.sv ***
// Counter that paces transmitted data bytes up to the programmed byte count
`default_nettype none
module cmf_tx_count (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic start,
  input wire logic [3:0] count,
  input wire logic byte_done,
  output logic busy,
  output logic [3:0] index
);
  logic [3:0] left_r;
  logic [3:0] idx_r;
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      left_r <= 4'h0;
      idx_r <= 4'h0;
    end else if (start) begin
      left_r <= (count > cmf_pkg::BC_MAX) ? cmf_pkg::BC_MAX : count;
      idx_r <= 4'h0;
    end else if (byte_done && left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
      idx_r <= idx_r + 4'h1;
    end
  end
  assign busy = left_r != 4'h0;
  assign index = idx_r;
endmodule
`default_nettype wire

// *** core/cmf_top.sv ***
// Message center format register and acceptance filter with APB slave
//
// Added by the designer: the register offsets and the APB interface to the registers.
`default_nettype none
module cmf_top (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Frame engine side: received frame offered for acceptance
  input wire logic RX_VALID,
  input wire logic [28:0] RX_ID,
  input wire logic RX_EXT,
  input wire logic RX_RTR,
  input wire logic [3:0] RX_DLC,
  input wire logic [15:0] RX_DATA01,
  output logic RX_ACCEPT,
  output logic RX_REJECT,
  output logic REMOTE_ANSWER,
  // Frame engine side: transmission
  input wire logic TX_START,
  input wire logic TX_BYTE_DONE,
  output logic TX_ENABLE,
  output logic TX_EXT,
  output logic [3:0] TX_DLC,
  output logic TX_BUSY,
  output logic [3:0] TX_INDEX
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] format_r;
  logic [28:0] arb_r;
  logic [28:0] mask_r;
  logic [15:0] dmask_r;
  logic ready_r;
  logic [28:0] rxid_r;
  logic acc_r;
  logic rej_r;
  logic rem_r;
  logic [31:0] prdata_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] format_nxt;
  logic [3:0] rx_dlc_r;
  logic [28:0] rx_id_hold_r;

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign addr_ok = (PADDR == cmf_pkg::ADDR_FORMAT) || (PADDR == cmf_pkg::ADDR_ARB) ||
                   (PADDR == cmf_pkg::ADDR_MASK) || (PADDR == cmf_pkg::ADDR_CTRL) ||
                   (PADDR == cmf_pkg::ADDR_RXID) || (PADDR == cmf_pkg::ADDR_STAT);
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance test
  logic id_hit;
  logic data_hit;
  logic fmt_ok;
  logic rx_ok;
  logic [28:0] id_cut;
  logic [28:0] arb_cut;

  // Standard frames compare only the low 11 identifier bits
  assign id_cut = format_r[cmf_pkg::FMT_BIT] ? RX_ID : {18'h0, RX_ID[10:0]};
  assign arb_cut = format_r[cmf_pkg::FMT_BIT] ? arb_r : {18'h0, arb_r[10:0]};
  assign fmt_ok = RX_EXT == format_r[cmf_pkg::FMT_BIT];

  cmf_id_cmp #(.W(29)) u_id (
    .rx(id_cut),
    .arb(arb_cut),
    .mask(mask_r),
    .use_mask(format_r[cmf_pkg::IDM_BIT]),
    .hit(id_hit)
  );
  cmf_id_cmp #(.W(16)) u_data (
    .rx(RX_DATA01),
    .arb(arb_r[15:0]),
    .mask(dmask_r),
    .use_mask(1'b1),
    .hit(data_hit)
  );

  // Data bytes are only tested when enabled and not in a remote frame
  assign rx_ok = fmt_ok && id_hit &&
                 (!format_r[cmf_pkg::DBM_BIT] || RX_RTR || data_hit);

  // Registered pulses back to the frame engine
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      acc_r <= 1'b0;
      rej_r <= 1'b0;
      rem_r <= 1'b0;
    end else begin
      acc_r <= RX_VALID && ready_r && rx_ok && !RX_RTR && !format_r[cmf_pkg::DIR_BIT];
      rej_r <= RX_VALID && !(ready_r && rx_ok);
      rem_r <= RX_VALID && ready_r && rx_ok && RX_RTR && format_r[cmf_pkg::DIR_BIT];
    end
  end
  assign RX_ACCEPT = acc_r;
  assign RX_REJECT = rej_r;
  assign REMOTE_ANSWER = rem_r;

  ////////////////////////////////////////////////////////////////////////////
  // Format register
  always_comb begin
    format_nxt = format_r;
    if (wr_en && PADDR == cmf_pkg::ADDR_FORMAT) begin
      format_nxt[cmf_pkg::BC_HI:cmf_pkg::BC_LO] = PWDATA[cmf_pkg::BC_HI:cmf_pkg::BC_LO];
      format_nxt[cmf_pkg::FMT_BIT] = PWDATA[cmf_pkg::FMT_BIT];
      if (!ready_r) begin
        format_nxt[cmf_pkg::DIR_BIT] = PWDATA[cmf_pkg::DIR_BIT];
        format_nxt[cmf_pkg::IDM_BIT] = PWDATA[cmf_pkg::IDM_BIT];
        format_nxt[cmf_pkg::DBM_BIT] = PWDATA[cmf_pkg::DBM_BIT];
      end
    end
    // Hardware load of the received byte count wins over a software write
    if (acc_r) begin
      format_nxt[cmf_pkg::BC_HI:cmf_pkg::BC_LO] = rx_dlc_r;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      rx_dlc_r <= 4'h0;
      rx_id_hold_r <= 29'h0;
    end else if (RX_VALID) begin
      rx_dlc_r <= RX_DLC;
      rx_id_hold_r <= RX_ID;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      format_r <= cmf_pkg::FORMAT_RST;
    end else begin
      format_r <= format_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration, masks, ready flag, received identifier
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      arb_r <= cmf_pkg::ARB_RST;
      rxid_r <= 29'h0;
    end else if (acc_r) begin
      arb_r <= rx_id_hold_r;
      rxid_r <= rx_id_hold_r;
    end else if (wr_en && PADDR == cmf_pkg::ADDR_ARB) begin
      arb_r <= PWDATA[28:0];
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      mask_r <= cmf_pkg::MASK_RST;
      dmask_r <= cmf_pkg::DMASK_RST;
    end else begin
      if (wr_en && PADDR == cmf_pkg::ADDR_MASK) begin
        mask_r <= PWDATA[28:0];
      end
      if (wr_en && PADDR == cmf_pkg::ADDR_CTRL) begin
        dmask_r <= PWDATA[31:16];
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      ready_r <= 1'b0;
    end else if (wr_en && PADDR == cmf_pkg::ADDR_CTRL) begin
      ready_r <= PWDATA[cmf_pkg::RDY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      prdata_r <= cmf_pkg::RD_ZERO;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        cmf_pkg::ADDR_FORMAT: prdata_r <= {24'h0, format_r};
        cmf_pkg::ADDR_ARB: prdata_r <= {3'h0, arb_r};
        cmf_pkg::ADDR_MASK: prdata_r <= {3'h0, mask_r};
        cmf_pkg::ADDR_CTRL: prdata_r <= {dmask_r, 15'h0, ready_r};
        cmf_pkg::ADDR_RXID: prdata_r <= {3'h0, rxid_r};
        cmf_pkg::ADDR_STAT: prdata_r <= {27'h0, TX_BUSY, TX_INDEX};
        default: prdata_r <= cmf_pkg::RD_ZERO;
      endcase
    end
  end
  assign PRDATA = rd_en ? prdata_r : cmf_pkg::RD_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit side
  assign TX_ENABLE = ready_r && format_r[cmf_pkg::DIR_BIT];
  assign TX_EXT = format_r[cmf_pkg::FMT_BIT];
  assign TX_DLC = format_r[cmf_pkg::BC_HI:cmf_pkg::BC_LO];

  cmf_tx_count u_tx (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .start(TX_START && TX_ENABLE),
    .count(TX_DLC),
    .byte_done(TX_BYTE_DONE),
    .busy(TX_BUSY),
    .index(TX_INDEX)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_locked_write;
    ready_r && wr_en && PADDR == cmf_pkg::ADDR_FORMAT;
  endsequence

  // Byte target seen by the transmit checks, taken when a start is honoured
  logic [3:0] tx_goal_r;
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      tx_goal_r <= 4'h0;
    end else if (TX_START && TX_ENABLE) begin
      tx_goal_r <= (TX_DLC > cmf_pkg::BC_MAX) ? cmf_pkg::BC_MAX : TX_DLC;
    end
  end

  // Ready center, exact identifier, data bytes not tested
  sequence s_rx_exact;
    RX_VALID && ready_r && fmt_ok && !format_r[cmf_pkg::IDM_BIT] && id_cut == arb_cut &&
    !format_r[cmf_pkg::DBM_BIT];
  endsequence
  sequence s_tx_begin;
    TX_START && TX_ENABLE;
  endsequence

  AST_LOCK_DIR: assert property (@(posedge CLOCK) disable iff (RESET)
    s_locked_write |=> $stable(format_r[cmf_pkg::DIR_BIT]))
    else $error("direction changed while ready");
  AST_LOCK_MASKS: assert property (@(posedge CLOCK) disable iff (RESET)
    s_locked_write |=> $stable(format_r[1:0]))
    else $error("mask enable changed while ready");
  AST_DLC_LOAD: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && ready_r && rx_ok && !RX_RTR && !format_r[cmf_pkg::DIR_BIT])
    |=> ##1 format_r[7:4] == $past(RX_DLC, 2))
    else $error("byte count not loaded");
  AST_FMT_ONLY: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && RX_EXT != format_r[cmf_pkg::FMT_BIT]) |=> RX_REJECT)
    else $error("wrong format accepted");
  AST_EXACT: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && !format_r[cmf_pkg::IDM_BIT] && id_cut != arb_cut) |=> !RX_ACCEPT && !REMOTE_ANSWER)
    else $error("inexact match accepted without masking");
  AST_REMOTE: assert property (@(posedge CLOCK) disable iff (RESET)
    REMOTE_ANSWER |-> $past(RX_RTR) && $past(format_r[cmf_pkg::IDM_BIT] || id_cut == arb_cut))
    else $error("remote answered without exact match");
  AST_MASKED: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && ready_r && fmt_ok && format_r[cmf_pkg::IDM_BIT] && !format_r[0] && RX_RTR == format_r[3] &&
     ((id_cut ^ arb_cut) & mask_r) == 29'h0) |=> (RX_ACCEPT || REMOTE_ANSWER))
    else $error("masked match not accepted");
  AST_ARB_LOAD: assert property (@(posedge CLOCK) disable iff (RESET)
    RX_ACCEPT |=> arb_r == $past(rx_id_hold_r))
    else $error("arbitration bits not loaded");
  AST_DATA: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && format_r[0] && !RX_RTR && ((RX_DATA01 ^ arb_r[15:0]) & dmask_r) != 16'h0) |=> RX_REJECT)
    else $error("data byte test bypassed");
  AST_TX_COUNT: assert property (@(posedge CLOCK) disable iff (RESET)
    s_tx_begin ##0 (TX_DLC != 4'h0) |=> (TX_BUSY && TX_INDEX == 4'h0))
    else $error("transmit count not started");

  // Filter verdicts
  AST_ONE_VERDICT: assert property (@(posedge CLOCK) disable iff (RESET)
    $onehot0({RX_ACCEPT, RX_REJECT, REMOTE_ANSWER}))
    else $error("more than one filter verdict");
  AST_VERDICT_CAUSE: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_ACCEPT || RX_REJECT || REMOTE_ANSWER) |-> $past(RX_VALID))
    else $error("verdict without a frame");
  AST_RX_RECEIVER: assert property (@(posedge CLOCK) disable iff (RESET)
    RX_ACCEPT |-> !$past(format_r[cmf_pkg::DIR_BIT]))
    else $error("data frame stored by a transmitter");
  AST_REMOTE_SENDER: assert property (@(posedge CLOCK) disable iff (RESET)
    REMOTE_ANSWER |-> $past(format_r[cmf_pkg::DIR_BIT]))
    else $error("remote request answered by a receiver");
  AST_ACCEPT_FORMAT: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_ACCEPT || REMOTE_ANSWER) |-> $past(RX_EXT == format_r[cmf_pkg::FMT_BIT]))
    else $error("frame of the other format taken");
  AST_EXACT_HIT: assert property (@(posedge CLOCK) disable iff (RESET)
    s_rx_exact ##0 (!RX_RTR && !format_r[cmf_pkg::DIR_BIT]) |=> RX_ACCEPT)
    else $error("exact match not accepted");
  AST_REMOTE_HIT: assert property (@(posedge CLOCK) disable iff (RESET)
    s_rx_exact ##0 (RX_RTR && format_r[cmf_pkg::DIR_BIT]) |=> REMOTE_ANSWER)
    else $error("exact remote request not answered");
  AST_MASK_MISS: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && format_r[cmf_pkg::IDM_BIT] && ((id_cut ^ arb_cut) & mask_r) != 29'h0) |=> (!RX_ACCEPT && !REMOTE_ANSWER))
    else $error("masked mismatch accepted");
  AST_STD_LOW: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && ready_r && !RX_EXT && !format_r[cmf_pkg::FMT_BIT] && !format_r[cmf_pkg::IDM_BIT] &&
     !format_r[cmf_pkg::DBM_BIT] && !format_r[cmf_pkg::DIR_BIT] && !RX_RTR && RX_ID[10:0] == arb_r[10:0])
    |=> RX_ACCEPT)
    else $error("standard identifier low bits not accepted");
  AST_DATA_IGNORED: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && ready_r && fmt_ok && id_hit && !format_r[cmf_pkg::DBM_BIT] && !RX_RTR &&
     !format_r[cmf_pkg::DIR_BIT]) |=> RX_ACCEPT)
    else $error("data bytes compared while data masking off");
  AST_DATA_HIT: assert property (@(posedge CLOCK) disable iff (RESET)
    (RX_VALID && ready_r && fmt_ok && id_hit && format_r[cmf_pkg::DBM_BIT] && !RX_RTR &&
     !format_r[cmf_pkg::DIR_BIT] && ((RX_DATA01 ^ arb_r[15:0]) & dmask_r) == 16'h0) |=> RX_ACCEPT)
    else $error("frame passing both tests not accepted");
  AST_RXID_LOAD: assert property (@(posedge CLOCK) disable iff (RESET)
    RX_ACCEPT |=> rxid_r == $past(rx_id_hold_r))
    else $error("received identifier not kept");

  // Register contents
  AST_ARB_HOLD: assert property (@(posedge CLOCK) disable iff (RESET)
    (!acc_r && !(wr_en && PADDR == cmf_pkg::ADDR_ARB)) |=> $stable(arb_r))
    else $error("arbitration bits changed without cause");
  AST_FORMAT_HOLD: assert property (@(posedge CLOCK) disable iff (RESET)
    (!acc_r && !(wr_en && PADDR == cmf_pkg::ADDR_FORMAT)) |=> $stable(format_r))
    else $error("format register changed without cause");
  AST_OPEN_WRITE: assert property (@(posedge CLOCK) disable iff (RESET)
    (!ready_r && !acc_r && wr_en && PADDR == cmf_pkg::ADDR_FORMAT) |=> format_r == $past(PWDATA[7:0]))
    else $error("format write lost while not ready");
  AST_LOCKED_FREE: assert property (@(posedge CLOCK) disable iff (RESET)
    s_locked_write ##0 (!acc_r) |=> (format_r[7:4] == $past(PWDATA[7:4]) && format_r[2] == $past(PWDATA[2])))
    else $error("count or format bit locked while ready");
  AST_UNMAPPED: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_en && !addr_ok) |=> ($stable(mask_r) && $stable(dmask_r) && $stable(ready_r)))
    else $error("unmapped write changed a register");

  // Transmit pacing
  AST_TX_EMPTY: assert property (@(posedge CLOCK) disable iff (RESET)
    s_tx_begin ##0 (TX_DLC == 4'h0) |=> !TX_BUSY)
    else $error("busy with no bytes to send");
  AST_TX_STEP: assert property (@(posedge CLOCK) disable iff (RESET)
    (TX_BUSY && TX_BYTE_DONE && !(TX_START && TX_ENABLE)) |=> TX_INDEX == $past(TX_INDEX) + 4'h1)
    else $error("byte index not advanced");
  AST_TX_BOUND: assert property (@(posedge CLOCK) disable iff (RESET)
    TX_BUSY |-> TX_INDEX < cmf_pkg::BC_MAX)
    else $error("byte index beyond limit while busy");
  AST_TX_DONE: assert property (@(posedge CLOCK) disable iff (RESET)
    $fell(TX_BUSY) |-> TX_INDEX == tx_goal_r)
    else $error("transmission ended at wrong byte count");
endmodule
`default_nettype wire

// *** tb/cmf_peer.sv ***
// Far-side node model: offers received frames and paces transmitted bytes
`default_nettype none
module cmf_peer (
  input wire logic CLOCK,
  input wire logic tx_busy,
  input wire logic [3:0] gap,
  output logic rx_valid,
  output logic [28:0] rx_id,
  output logic rx_ext,
  output logic rx_rtr,
  output logic [3:0] rx_dlc,
  output logic [15:0] rx_data01,
  output logic byte_done,
  output int sent
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_r;
  initial begin
    rx_valid = 1'b0;
    rx_id = 29'h0;
    rx_ext = 1'b0;
    rx_rtr = 1'b0;
    rx_dlc = 4'h0;
    rx_data01 = 16'h0;
    byte_done = 1'b0;
    sent = 0;
    wait_r = 4'h0;
  end
  // One frame offered for a single cycle, then the lines show garbage
  task automatic send(input logic [28:0] id, input logic ext, input logic rtr, input logic [3:0] dlc,
                      input logic [15:0] d);
    @(posedge CLOCK);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_ext <= ext;
    rx_rtr <= rtr;
    rx_dlc <= dlc;
    rx_data01 <= d;
    @(posedge CLOCK);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_ext <= ~ext;
    rx_rtr <= ~rtr;
    rx_dlc <= ~dlc;
    rx_data01 <= ~d;
  endtask
  // Bytes leave the wire at a pace set by gap
  always @(posedge CLOCK) begin
    byte_done <= 1'b0;
    if (tx_busy === 1'b1 && !byte_done) begin
      if (wait_r == gap) begin
        byte_done <= 1'b1;
        wait_r <= 4'h0;
        sent <= sent + 1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/cmf_top_tb.sv ***
// Self-checking bench for the message center format and acceptance filter
`default_nettype none
module cmf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_F = cmf_pkg::ADDR_FORMAT;
  localparam logic [7:0] A_A = cmf_pkg::ADDR_ARB;
  localparam logic [7:0] A_C = cmf_pkg::ADDR_CTRL;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_start = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, lf = 32'h054E, prdata;
  logic pready, pslverr, acc, rej, rem, tx_en, tx_ext, tx_busy, rx_valid, rx_ext, rx_rtr, byte_done;
  logic [28:0] rx_id, arb;
  logic [3:0] rx_dlc, tx_dlc, tx_idx, gap = 4'h0;
  logic [15:0] rx_d;
  logic [32:0] exp_q[$];
  int errors = 0, num_checks = 0, cycles = 0, sent, n;
  always #25 CLOCK = ~CLOCK;
  cmf_top i_cmf_top (.CLOCK(CLOCK), .RESET(RESET), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_VALID(rx_valid), .RX_ID(rx_id), .RX_EXT(rx_ext), .RX_RTR(rx_rtr), .RX_DLC(rx_dlc),
    .RX_DATA01(rx_d), .RX_ACCEPT(acc), .RX_REJECT(rej), .REMOTE_ANSWER(rem), .TX_START(tx_start),
    .TX_BYTE_DONE(byte_done), .TX_ENABLE(tx_en), .TX_EXT(tx_ext), .TX_DLC(tx_dlc), .TX_BUSY(tx_busy),
    .TX_INDEX(tx_idx));
  cmf_peer i_cmf_peer (.CLOCK(CLOCK), .tx_busy(tx_busy), .gap(gap), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_ext(rx_ext), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data01(rx_d), .byte_done(byte_done), .sent(sent));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    if (exp_q.size() != 0) errors++;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLOCK);
    penable <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask
  // Ready flag dropped around the format write so the locked bits take
  task automatic cfg(input logic [7:0] f, input logic [15:0] dm);
    apb(1'b1, A_C, {dm, 16'h0});
    apb(1'b1, A_F, {24'h0, f});
    apb(1'b1, A_C, {dm, 16'h1});
  endtask
  task automatic frame(input logic [28:0] id, input logic ext, rtr, input logic [3:0] dlc,
                       input logic [15:0] d, input logic [2:0] res);
    lf = lfsr(lf);
    if (res != 3'b000) exp_q.push_back({30'h0, res});
    i_cmf_peer.send(id, ext, rtr, dlc, d);
    repeat (3) @(posedge CLOCK);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Oldest expectation is matched against each read or filter verdict
  always @(posedge CLOCK) begin
    if ((psel && penable && pready === 1'b1 && !pwrite) || (acc | rej | rem) === 1'b1) begin
      if (exp_q.size() == 0) check(33'h0, 33'h1);
      else if (psel && penable && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
      else check({30'h0, acc, rej, rem}, exp_q.pop_front());
    end
  end
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge CLOCK);
    RESET <= 1'b0;
    rd(A_F, 33'h0);
    lf = lfsr(lf);
    arb = lf[28:0];
    apb(1'b1, A_A, {3'h0, arb});
    apb(1'b1, cmf_pkg::ADDR_MASK, {3'h0, ~29'h1});
    cfg(8'h04, 16'hFFFF);
    rd(A_F, 33'h04);
    apb(1'b1, A_F, 32'hFB);
    rd(A_F, 33'hF0);
    check(tx_en, 33'h0);
    rd(8'h18, 33'h1_0000_0000);
    $display("test registers done");
    cfg(8'h04, 16'hFFFF);
    frame(arb, 1'b1, 1'b0, 4'h8, lf[31:16], 3'b100);
    rd(A_F, 33'h84);
    frame(arb ^ 29'h1, 1'b1, 1'b0, 4'h1, lf[31:16], 3'b010);
    frame(arb, 1'b0, 1'b0, 4'h1, lf[31:16], 3'b010);
    cfg(8'h06, 16'hFFFF);
    arb = arb ^ 29'h1;
    frame(arb, 1'b1, 1'b0, 4'h2, lf[31:16], 3'b100);
    rd(A_A, {4'h0, arb});
    rd(cmf_pkg::ADDR_RXID, {4'h0, arb});
    frame(arb ^ 29'h2, 1'b1, 1'b0, 4'h2, lf[31:16], 3'b010);
    cfg(8'h07, 16'h00FF);
    frame(arb, 1'b1, 1'b0, 4'h2, {~arb[15:8], arb[7:0]}, 3'b100);
    frame(arb, 1'b1, 1'b0, 4'h2, {arb[15:8], ~arb[7:0]}, 3'b010);
    cfg(8'h0C, 16'h0);
    frame(arb, 1'b1, 1'b1, 4'h0, lf[31:16], 3'b001);
    frame(arb ^ 29'h10, 1'b1, 1'b1, 4'h0, lf[31:16], 3'b010);
    apb(1'b1, A_C, 32'h0);
    frame(arb, 1'b1, 1'b1, 4'h0, lf[31:16], 3'b010);
    $display("test filter done");
    cfg(8'h3C, 16'h0);
    @(posedge CLOCK);
    check(tx_en, 33'h1);
    check(tx_ext, 33'h1);
    check(tx_dlc, 33'h3);
    n = sent;
    gap <= 4'h2;
    tx_start <= 1'b1;
    @(posedge CLOCK);
    tx_start <= 1'b0;
    repeat (2) @(posedge CLOCK);
    for (int k = 0; k < 200 && tx_busy !== 1'b0; k++) @(posedge CLOCK);
    check(sent - n, 33'h3);
    check(tx_idx, 33'h3);
    rd(cmf_pkg::ADDR_STAT, 33'h3);
    $display("test transmit done");
    repeat (4) @(posedge CLOCK);
    complete_run();
  end
endmodule
`default_nettype wire
